// *** rtl/mfc_config_page.sv ***
// motion feature configuration page with AHB-Lite register slave
//
// What this block does
// - hold 16-bit long counter limit; interrupt when running counter becomes equal.
// - 16-bit settings split in two bytes, low byte at lower address.
// - overflow-only option makes pedometer interrupt only on step count overflow.
// - false-positive rejection acts only while advanced step enable is also set.
// - advanced detection acts only when rejection and advanced step enable both set.
// - step counter increments only after debounce threshold of steps; threshold resets ten.
// - step delta time period is 16 bits, one unit per 6.4 ms.
`timescale 1ns/1ps
`default_nettype none
module mfc_config_page #(
   parameter int P_TICK_CYCLES = mfc_pkg::STEP_TICK_CYCLES
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rstn,
   // ahb-lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // state machine engine
   input wire logic [15:0] i_long_count,
   output logic [15:0] o_long_counter_limit,
   output logic [7:0] o_machine_program_count_field,
   output logic [15:0] o_program_base_field,
   output logic o_lc_timeout_irq,
   // step detector core
   input wire logic i_step,
   input wire logic i_advanced_step_enable,
   output logic o_false_positive_reject_active,
   output logic o_advanced_detect_active,
   output logic [7:0] o_step_debounce_field,
   output logic [15:0] o_step_period_field,
   output logic o_step_tick,
   output logic [15:0] o_step_count,
   output logic o_step_irq,
   output logic o_step_overflow
);
   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   function automatic logic [15:0] join16(input logic [7:0] hi, input logic [7:0] lo);
      join16 = {hi, lo};
   endfunction : join16

   function automatic logic [31:0] word8(input logic [7:0] b);
      word8 = {24'h000000, b};
   endfunction : word8

   // ----------------------------------------------------------
   // reset release
   // ----------------------------------------------------------
   logic rst_meta_q;
   logic rst_sync_q;
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   wire rstn = rst_sync_q;

   // ----------------------------------------------------------
   // bus front end
   // ----------------------------------------------------------
   mfc_pkg::mfc_bus_state_e state_q;
   logic hready_q;
   logic [31:0] hrdata_q;
   logic wr_pend_q;
   logic [7:0] wr_idx_q;
   logic [7:0] rd_idx_q;
   logic rd_hit_q;
   logic wr_hit_q;

   wire accept = i_hsel && i_htrans[1] && i_hready;
   // only the first 1 KB window holds registers; the rest aliases nowhere
   wire in_range = (i_haddr[31:10] == 22'h000000);
   wire [7:0] addr_idx = i_haddr[9:2];
   wire wr_en = wr_pend_q && wr_hit_q;

   always_ff @(posedge i_core_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= mfc_pkg::BUS_IDLE;
         hready_q <= 1'b1;
         wr_pend_q <= 1'b0;
         wr_idx_q <= 8'h00;
         rd_idx_q <= 8'h00;
         rd_hit_q <= 1'b0;
         wr_hit_q <= 1'b0;
      end else begin
         case (state_q)
            mfc_pkg::BUS_IDLE: begin
               wr_pend_q <= accept && i_hwrite;
               wr_idx_q <= addr_idx;
               wr_hit_q <= in_range;
               rd_idx_q <= addr_idx;
               rd_hit_q <= in_range;
               // one wait state on reads lets a write just before land first
               if (accept && !i_hwrite) begin
                  state_q <= mfc_pkg::BUS_READ;
                  hready_q <= 1'b0;
               end
            end
            mfc_pkg::BUS_READ: begin
               wr_pend_q <= 1'b0;
               state_q <= mfc_pkg::BUS_IDLE;
               hready_q <= 1'b1;
            end
            default: begin
               state_q <= mfc_pkg::BUS_IDLE;
               hready_q <= 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------
   logic [7:0] lc_lo_q;
   logic [7:0] lc_hi_q;
   logic [7:0] prog_count_q;
   logic [7:0] base_lo_q;
   logic [7:0] base_hi_q;
   logic [7:0] option_q;
   logic [7:0] debounce_q;
   logic [7:0] period_lo_q;
   logic [7:0] period_hi_q;

   wire [7:0] wbyte = i_hwdata[7:0];
   wire wr_lc_lo = wr_en && (wr_idx_q == mfc_pkg::IDX_LC_LIMIT_LO);
   wire wr_lc_hi = wr_en && (wr_idx_q == mfc_pkg::IDX_LC_LIMIT_HI);
   wire wr_prog = wr_en && (wr_idx_q == mfc_pkg::IDX_PROG_COUNT);
   wire wr_base_lo = wr_en && (wr_idx_q == mfc_pkg::IDX_PROG_BASE_LO);
   wire wr_base_hi = wr_en && (wr_idx_q == mfc_pkg::IDX_PROG_BASE_HI);
   wire wr_option = wr_en && (wr_idx_q == mfc_pkg::IDX_STEP_OPTION);
   wire wr_deb = wr_en && (wr_idx_q == mfc_pkg::IDX_STEP_DEBOUNCE);
   wire wr_per_lo = wr_en && (wr_idx_q == mfc_pkg::IDX_STEP_PERIOD_LO);
   wire wr_per_hi = wr_en && (wr_idx_q == mfc_pkg::IDX_STEP_PERIOD_HI);

   always_ff @(posedge i_core_clk or negedge rstn) begin
      if (!rstn) begin
         lc_lo_q <= mfc_pkg::RST_LC_LIMIT;
         lc_hi_q <= mfc_pkg::RST_LC_LIMIT;
         base_lo_q <= mfc_pkg::RST_PROG_BASE;
         base_hi_q <= mfc_pkg::RST_PROG_BASE;
      end else begin
         if (wr_lc_lo) lc_lo_q <= wbyte;
         if (wr_lc_hi) lc_hi_q <= wbyte;
         if (wr_base_lo) base_lo_q <= wbyte;
         if (wr_base_hi) base_hi_q <= wbyte;
      end
   end

   always_ff @(posedge i_core_clk or negedge rstn) begin
      if (!rstn) begin
         prog_count_q <= mfc_pkg::RST_PROG_COUNT;
         option_q <= mfc_pkg::RST_STEP_OPTION;
         debounce_q <= mfc_pkg::RST_STEP_DEBOUNCE;
         period_lo_q <= mfc_pkg::RST_STEP_PERIOD;
         period_hi_q <= mfc_pkg::RST_STEP_PERIOD;
      end else begin
         // stored as written; the engine owns any range check
         if (wr_prog) prog_count_q <= wbyte;
         // reserved bits are not stored and read back zero
         if (wr_option) option_q <= wbyte & mfc_pkg::OPT_WRITABLE_MASK;
         if (wr_deb) debounce_q <= wbyte;
         if (wr_per_lo) period_lo_q <= wbyte;
         if (wr_per_hi) period_hi_q <= wbyte;
      end
   end

   // ----------------------------------------------------------
   // option gating
   // ----------------------------------------------------------
   wire fp_active = option_q[mfc_pkg::OPT_FP_REJECT_BIT] && i_advanced_step_enable;
   wire ad_active = option_q[mfc_pkg::OPT_ADV_DETECT_BIT] && fp_active;
   logic fp_active_q;
   logic ad_active_q;
   always_ff @(posedge i_core_clk or negedge rstn) begin
      if (!rstn) begin
         fp_active_q <= 1'b0;
         ad_active_q <= 1'b0;
      end else begin
         fp_active_q <= fp_active;
         ad_active_q <= ad_active;
      end
   end

   // ----------------------------------------------------------
   // long counter limit compare
   // ----------------------------------------------------------
   wire [15:0] lc_limit = join16(lc_hi_q, lc_lo_q);
   wire lc_equal = (i_long_count == lc_limit);
   logic lc_equal_q;
   logic lc_irq_q;
   always_ff @(posedge i_core_clk or negedge rstn) begin
      if (!rstn) begin
         lc_equal_q <= 1'b0;
         lc_irq_q <= 1'b0;
      end else begin
         lc_equal_q <= lc_equal;
         // pulse once when equality starts, not every cycle it holds
         lc_irq_q <= lc_equal && !lc_equal_q;
      end
   end

   // ----------------------------------------------------------
   // step period time base
   // ----------------------------------------------------------
   logic [31:0] tick_cnt_q;
   logic tick_q;
   wire tick_wrap = (tick_cnt_q == 32'(P_TICK_CYCLES - 1));
   always_ff @(posedge i_core_clk or negedge rstn) begin
      if (!rstn) begin
         tick_cnt_q <= 32'h00000000;
         tick_q <= 1'b0;
      end else begin
         tick_cnt_q <= tick_wrap ? 32'h00000000 : tick_cnt_q + 32'h00000001;
         tick_q <= tick_wrap;
      end
   end

   // ----------------------------------------------------------
   // step counter
   // ----------------------------------------------------------
   wire [15:0] step_period = join16(period_hi_q, period_lo_q);
   wire [15:0] step_count;
   wire step_debounced;
   wire step_irq;
   wire step_ovf;
   mfc_step_counter #(
      .CNT_W(16)
   ) u_step (
      .i_clk(i_core_clk),
      .i_rstn(rstn),
      .i_step(i_step),
      .i_tick(tick_q),
      .i_period(step_period),
      .i_threshold(debounce_q),
      .i_carry_only(option_q[mfc_pkg::OPT_CARRY_ONLY_BIT]),
      .o_count(step_count),
      .o_debounced(step_debounced),
      .o_irq(step_irq),
      .o_overflow(step_ovf)
   );

   // ----------------------------------------------------------
   // read mux
   // ----------------------------------------------------------
   wire [7:0] status = {5'h00, step_debounced, ad_active_q, fp_active_q};
   wire [7:0] rd_byte =
      (rd_idx_q == mfc_pkg::IDX_LC_LIMIT_LO) ? lc_lo_q :
      (rd_idx_q == mfc_pkg::IDX_LC_LIMIT_HI) ? lc_hi_q :
      (rd_idx_q == mfc_pkg::IDX_PROG_COUNT) ? prog_count_q :
      (rd_idx_q == mfc_pkg::IDX_PROG_BASE_LO) ? base_lo_q :
      (rd_idx_q == mfc_pkg::IDX_PROG_BASE_HI) ? base_hi_q :
      (rd_idx_q == mfc_pkg::IDX_STEP_OPTION) ? option_q :
      (rd_idx_q == mfc_pkg::IDX_STEP_DEBOUNCE) ? debounce_q :
      (rd_idx_q == mfc_pkg::IDX_STEP_PERIOD_LO) ? period_lo_q :
      (rd_idx_q == mfc_pkg::IDX_STEP_PERIOD_HI) ? period_hi_q :
      (rd_idx_q == mfc_pkg::IDX_STEP_COUNT_LO) ? step_count[7:0] :
      (rd_idx_q == mfc_pkg::IDX_STEP_COUNT_HI) ? step_count[15:8] :
      (rd_idx_q == mfc_pkg::IDX_STATUS) ? status :
      8'h00;

   // reads touch no state, so a read never disturbs the block
   always_ff @(posedge i_core_clk or negedge rstn) begin
      if (!rstn) begin
         hrdata_q <= 32'h00000000;
      end else if (state_q == mfc_pkg::BUS_READ) begin
         hrdata_q <= rd_hit_q ? word8(rd_byte) : 32'h00000000;
      end
   end

   // ----------------------------------------------------------
   // output registers
   // ----------------------------------------------------------
   logic step_irq_q;
   logic step_ovf_q;
   logic [15:0] step_count_q;
   always_ff @(posedge i_core_clk or negedge rstn) begin
      if (!rstn) begin
         step_irq_q <= 1'b0;
         step_ovf_q <= 1'b0;
         step_count_q <= 16'h0000;
      end else begin
         step_irq_q <= step_irq;
         step_ovf_q <= step_ovf;
         step_count_q <= step_count;
      end
   end

   logic hresp_q;
   always_ff @(posedge i_core_clk or negedge rstn) begin
      if (!rstn) begin
         hresp_q <= 1'b0;
      end else begin
         hresp_q <= 1'b0;
      end
   end

   assign o_hrdata = hrdata_q;
   assign o_hreadyout = hready_q;
   assign o_hresp = hresp_q;
   assign o_long_counter_limit = {lc_hi_q, lc_lo_q};
   assign o_machine_program_count_field = prog_count_q;
   assign o_program_base_field = {base_hi_q, base_lo_q};
   assign o_lc_timeout_irq = lc_irq_q;
   assign o_false_positive_reject_active = fp_active_q;
   assign o_advanced_detect_active = ad_active_q;
   assign o_step_debounce_field = debounce_q;
   assign o_step_period_field = {period_hi_q, period_lo_q};
   assign o_step_tick = tick_q;
   assign o_step_count = step_count_q;
   assign o_step_irq = step_irq_q;
   assign o_step_overflow = step_ovf_q;
endmodule : mfc_config_page
`default_nettype wire

// *** rtl/mfc_pkg.sv ***
// constants for the motion feature configuration page
package mfc_pkg;
   // ----------------------------------------------------------
   // register indices; byte address is four times the index
   // ----------------------------------------------------------
   localparam logic [7:0] IDX_LC_LIMIT_LO = 8'h7a;
   localparam logic [7:0] IDX_LC_LIMIT_HI = 8'h7b;
   localparam logic [7:0] IDX_PROG_COUNT = 8'h7c;
   localparam logic [7:0] IDX_PROG_BASE_LO = 8'h7e;
   localparam logic [7:0] IDX_PROG_BASE_HI = 8'h7f;
   localparam logic [7:0] IDX_STEP_OPTION = 8'h83;
   localparam logic [7:0] IDX_STEP_DEBOUNCE = 8'h84;
   localparam logic [7:0] IDX_STEP_PERIOD_LO = 8'hd0;
   localparam logic [7:0] IDX_STEP_PERIOD_HI = 8'hd1;
   localparam logic [7:0] IDX_STEP_COUNT_LO = 8'he0;
   localparam logic [7:0] IDX_STEP_COUNT_HI = 8'he1;
   localparam logic [7:0] IDX_STATUS = 8'he2;
   // ----------------------------------------------------------
   // reset values
   // ----------------------------------------------------------
   localparam logic [7:0] RST_LC_LIMIT = 8'h00;
   localparam logic [7:0] RST_PROG_COUNT = 8'h00;
   localparam logic [7:0] RST_PROG_BASE = 8'h00;
   localparam logic [7:0] RST_STEP_OPTION = 8'h00;
   localparam logic [7:0] RST_STEP_DEBOUNCE = 8'h0a;
   localparam logic [7:0] RST_STEP_PERIOD = 8'h00;
   // ----------------------------------------------------------
   // step option field positions
   // ----------------------------------------------------------
   localparam int OPT_ADV_DETECT_BIT = 0;
   localparam int OPT_FP_REJECT_BIT = 2;
   localparam int OPT_CARRY_ONLY_BIT = 3;
   localparam logic [7:0] OPT_WRITABLE_MASK = 8'h0d;
   // ----------------------------------------------------------
   // status field positions
   // ----------------------------------------------------------
   localparam int STAT_FP_ACTIVE_BIT = 0;
   localparam int STAT_AD_ACTIVE_BIT = 1;
   localparam int STAT_DEBOUNCED_BIT = 2;
   // ----------------------------------------------------------
   // timing
   // ----------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam longint STEP_PERIOD_LSB_PS = 64'd6400000000;
   localparam int STEP_TICK_CYCLES = int'(STEP_PERIOD_LSB_PS / CLK_PERIOD_PS);
   // ----------------------------------------------------------
   // bus slave states
   // ----------------------------------------------------------
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_READ = 2'b01
   } mfc_bus_state_e;
endpackage : mfc_pkg

// *** rtl/mfc_step_counter.sv ***
// step debounce, delta time window and step counter
`timescale 1ns/1ps
`default_nettype none
module mfc_step_counter #(
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // step detector and time base
   input wire logic i_step,
   input wire logic i_tick,
   // configuration
   input wire logic [15:0] i_period,
   input wire logic [7:0] i_threshold,
   input wire logic i_carry_only,
   // results
   output logic [CNT_W-1:0] o_count,
   output logic o_debounced,
   output logic o_irq,
   output logic o_overflow
);
   logic [7:0] deb_q;
   logic [15:0] idle_q;
   logic [CNT_W-1:0] count_q;
   logic irq_q;
   logic ovf_q;
   // ----------------------------------------------------------
   // decode
   // ----------------------------------------------------------
   wire window_over = (i_period != 16'h0000) && (idle_q >= i_period);
   wire [8:0] deb_next = {1'b0, deb_q} + 9'h001;
   wire passed = deb_next >= {1'b0, i_threshold};
   wire count_step = i_step && passed;
   wire wrap = count_step && (&count_q);
   // ----------------------------------------------------------
   // counters
   // ----------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         deb_q <= 8'h00;
         idle_q <= 16'h0000;
      end else if (i_step) begin
         // saturate so a long walk never re-arms the debounce
         deb_q <= passed ? i_threshold : deb_next[7:0];
         idle_q <= 16'h0000;
      end else if (window_over) begin
         deb_q <= 8'h00;
         idle_q <= 16'h0000;
      end else if (i_tick) begin
         idle_q <= idle_q + 16'h0001;
      end
   end
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         count_q <= '0;
         irq_q <= 1'b0;
         ovf_q <= 1'b0;
      end else begin
         if (count_step) begin
            count_q <= count_q + 1'b1;
         end
         irq_q <= i_carry_only ? wrap : count_step;
         ovf_q <= wrap;
      end
   end
   assign o_count = count_q;
   assign o_debounced = (deb_q >= i_threshold);
   assign o_irq = irq_q;
   assign o_overflow = ovf_q;
endmodule : mfc_step_counter
`default_nettype wire

// *** test/mfc_config_page_assertions.sv ***
// port-level assertions for the motion feature configuration page
`timescale 1ns/1ps
`default_nettype none
module mfc_config_page_checker #(
   parameter int P_TICK_CYCLES = 4
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rstn,
   // bus
   input wire logic i_hsel,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic i_hready,
   input wire logic o_hreadyout,
   // engine and step core
   input wire logic [15:0] i_long_count,
   input wire logic [15:0] o_long_counter_limit,
   input wire logic o_lc_timeout_irq,
   input wire logic i_step,
   input wire logic i_advanced_step_enable,
   input wire logic o_false_positive_reject_active,
   input wire logic o_advanced_detect_active,
   input wire logic [7:0] o_step_debounce_field,
   input wire logic o_step_tick,
   input wire logic [15:0] o_step_count,
   input wire logic o_step_irq
);
   // ----------------------------------------
   // helper logic
   // ----------------------------------------
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rstn);
   logic take;
   logic lc_eq;
   logic wr_dp_q;
   logic seen_q;
   int gap_q;
   assign take = i_hsel & i_htrans[1] & i_hready;
   assign lc_eq = (i_long_count == o_long_counter_limit);
   // gap only trusted once a first tick has been seen
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         wr_dp_q <= 1'b0;
         seen_q <= 1'b0;
         gap_q <= 0;
      end else begin
         wr_dp_q <= take & i_hwrite;
         seen_q <= seen_q | o_step_tick;
         gap_q <= o_step_tick ? 0 : gap_q + 1;
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   AST_READ_ONE_WAIT: assert property (take && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
      else $error("read data phase without exactly one wait state");
   AST_WRITE_NO_WAIT: assert property (take && i_hwrite |=> o_hreadyout)
      else $error("write data phase stalled");
   AST_CFG_ONLY_BY_WRITE: assert property (!$stable(o_step_debounce_field) || !$stable(o_long_counter_limit)
      |-> $past(wr_dp_q)) else $error("configuration changed without a write");
   AST_LC_ON_EQUAL: assert property ($rose(lc_eq) |=> o_lc_timeout_irq)
      else $error("no timeout pulse when long count met limit");
   AST_LC_CAUSE: assert property (o_lc_timeout_irq |-> $past(lc_eq) && !$past(lc_eq, 2))
      else $error("timeout pulse without fresh equality");
   AST_FP_NEEDS_ENABLE: assert property (o_false_positive_reject_active |-> $past(i_advanced_step_enable))
      else $error("rejection active without advanced step enable");
   AST_ADV_NEEDS_FP: assert property (o_advanced_detect_active |-> o_false_positive_reject_active)
      else $error("advanced detection active without rejection");
   AST_COUNT_AFTER_STEP: assert property (!$stable(o_step_count) |-> $past(i_step, 2))
      else $error("step count moved without a step");
   AST_IRQ_AFTER_STEP: assert property (o_step_irq |-> $past(i_step, 2))
      else $error("step interrupt without a step");
   AST_TICK_SPACING: assert property (o_step_tick && seen_q |-> gap_q == P_TICK_CYCLES - 1)
      else $error("step time base tick spacing wrong");
endmodule : mfc_config_page_checker
bind mfc_config_page mfc_config_page_checker #(.P_TICK_CYCLES(P_TICK_CYCLES)) i_chk (.i_core_clk, .i_rstn,
   .i_hsel, .i_htrans, .i_hwrite, .i_hready, .o_hreadyout, .i_long_count, .o_long_counter_limit,
   .o_lc_timeout_irq, .i_step, .i_advanced_step_enable, .o_false_positive_reject_active,
   .o_advanced_detect_active, .o_step_debounce_field, .o_step_tick, .o_step_count, .o_step_irq);
`default_nettype wire

// *** test/test_mfc_config_page.sv ***
// self-checking bench for the motion feature configuration page
`timescale 1ns/1ps
`default_nettype none
module test_mfc_config_page;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   localparam int TICKS = 4;
   logic clk, rstn, hsel, hwrite, step, adv_en, rd_pend, lc_irq, fp_act, ad_act, tick, st_irq, ovf, hresp;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rnd;
   logic [15:0] lc, lc_lim, base, period, cnt;
   logic [7:0] progs, deb;
   logic [7:0] v [9];
   logic [31:0] expq [$];
   wire logic hready;
   int n_errors, checks_done, n, n_ovf;
   localparam logic [7:0] IDX [9] = '{mfc_pkg::IDX_LC_LIMIT_LO, mfc_pkg::IDX_LC_LIMIT_HI,
      mfc_pkg::IDX_PROG_COUNT, mfc_pkg::IDX_PROG_BASE_LO, mfc_pkg::IDX_PROG_BASE_HI, mfc_pkg::IDX_STEP_OPTION,
      mfc_pkg::IDX_STEP_DEBOUNCE, mfc_pkg::IDX_STEP_PERIOD_LO, mfc_pkg::IDX_STEP_PERIOD_HI};
   localparam logic [7:0] RST [9] = '{mfc_pkg::RST_LC_LIMIT, mfc_pkg::RST_LC_LIMIT, mfc_pkg::RST_PROG_COUNT,
      mfc_pkg::RST_PROG_BASE, mfc_pkg::RST_PROG_BASE, mfc_pkg::RST_STEP_OPTION, mfc_pkg::RST_STEP_DEBOUNCE,
      mfc_pkg::RST_STEP_PERIOD, mfc_pkg::RST_STEP_PERIOD};
   // word size tied: the page ignores it
   mfc_config_page #(.P_TICK_CYCLES(TICKS)) i_mfc_config_page (.i_core_clk(clk), .i_rstn(rstn),
      .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010),
      .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
      .i_long_count(lc), .o_long_counter_limit(lc_lim), .o_machine_program_count_field(progs),
      .o_program_base_field(base), .o_lc_timeout_irq(lc_irq), .i_step(step), .i_advanced_step_enable(adv_en),
      .o_false_positive_reject_active(fp_act), .o_advanced_detect_active(ad_act), .o_step_debounce_field(deb),
      .o_step_period_field(period), .o_step_tick(tick), .o_step_count(cnt), .o_step_irq(st_irq),
      .o_step_overflow(ovf));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wrap_up;
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : wrap_up
   // master holds each phase until hready is seen high
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      do @(posedge clk); while (hready !== 1'b1);
   endtask : bus
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      expq.push_back({24'h0, exp});
      bus(1'b0, idx, 8'h00);
   endtask : rd
   // one step every four cycles, interrupts counted over the whole run
   task automatic steps(input int k, output int irqs);
      irqs = 0;
      for (int c = 0; c < 4 * k + 4; c++) begin
         step <= (c % 4 == 0) && (c < 4 * k);
         @(posedge clk);
         irqs += int'(st_irq === 1'b1);
      end
   endtask : steps
   // ----------------------------------------
   // clock, monitor and watchdog
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (rd_pend && hready === 1'b1) begin
         check("read data", hrdata, expq.pop_front());
         check("read response", {31'h0, hresp}, 32'h0);
         rd_pend = 1'b0;
      end
      if (hsel === 1'b1 && htrans[1] === 1'b1 && hready === 1'b1 && hwrite === 1'b0) begin
         rd_pend = 1'b1;
      end
   end
   always @(posedge clk) n_ovf += int'(ovf === 1'b1);
   initial begin
      repeat (70000) @(posedge clk);
      n_errors++;
      wrap_up();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {rstn, hsel, hwrite, step, adv_en, rd_pend, htrans, haddr, hwdata} = '0;
      {n_errors, checks_done, n_ovf} = '0;
      lc = 16'h0001;
      rnd = 32'h734f9e1e;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
         rd(IDX[i], RST[i]);
      end
      check("debounce out", {24'h0, deb}, 32'h0000000a);
      check("program count out", {24'h0, progs}, 32'h0);
      for (int i = 0; i < 9; i++) begin
         rnd = lfsr(rnd);
         v[i] = rnd[7:0];
      end
      v[2] = 8'(rnd[15:8] % 8'd17);
      v[4] = {4'h0, rnd[19:16]} | 8'h04;
      v[5] = v[5] & mfc_pkg::OPT_WRITABLE_MASK;
      for (int i = 0; i < 9; i++) begin
         bus(1'b1, IDX[i], v[i]);
         rd(IDX[i], v[i]);
      end
      check("limit", {16'h0, lc_lim}, {16'h0, v[1], v[0]});
      check("program count", {24'h0, progs}, {24'h0, v[2]});
      check("program base", {16'h0, base}, {16'h0, v[4], v[3]});
      check("debounce", {24'h0, deb}, {24'h0, v[6]});
      check("period", {16'h0, period}, {16'h0, v[8], v[7]});
      bus(1'b1, 8'h7d, 8'hff);
      rd(8'h7d, 8'h00);
      bus(1'b1, mfc_pkg::IDX_STEP_OPTION, 8'hf2);
      rd(mfc_pkg::IDX_STEP_OPTION, 8'h00);
      for (int k = 0; k < 8; k++) begin
         bus(1'b1, mfc_pkg::IDX_STEP_OPTION, {5'h0, k[1], 1'b0, k[0]});
         adv_en <= k[2];
         repeat (3) @(posedge clk);
         check("rejection active", {31'h0, fp_act}, {31'h0, k[1] & k[2]});
         check("advanced active", {31'h0, ad_act}, {31'h0, k[0] & k[1] & k[2]});
      end
      bus(1'b1, mfc_pkg::IDX_LC_LIMIT_LO, 8'h34);
      bus(1'b1, mfc_pkg::IDX_LC_LIMIT_HI, 8'h12);
      n = 0;
      for (int i = 0; i < 20; i++) begin
         lc <= (i < 4) ? 16'h1230 + 16'(i) : (i == 8 || i == 9) ? 16'h1235 : (i < 16) ? 16'h1234 : 16'h0001;
         @(posedge clk);
         n += int'(lc_irq === 1'b1);
      end
      check("timeout pulses", 32'(n), 32'd2);
      bus(1'b1, mfc_pkg::IDX_STEP_OPTION, 8'h00);
      bus(1'b1, mfc_pkg::IDX_STEP_PERIOD_LO, 8'h00);
      bus(1'b1, mfc_pkg::IDX_STEP_PERIOD_HI, 8'h00);
      bus(1'b1, mfc_pkg::IDX_STEP_DEBOUNCE, 8'h03);
      steps(5, n);
      check("debounced irqs", 32'(n), 32'd3);
      check("step count", {16'h0, cnt}, 32'd3);
      rd(mfc_pkg::IDX_STEP_COUNT_LO, 8'h03);
      bus(1'b1, mfc_pkg::IDX_STEP_OPTION, 8'h08);
      steps(2, n);
      check("overflow only irqs", 32'(n), 32'd0);
      check("step count", {16'h0, cnt}, 32'd5);
      bus(1'b1, mfc_pkg::IDX_STEP_OPTION, 8'h00);
      bus(1'b1, mfc_pkg::IDX_STEP_PERIOD_LO, 8'h02);
      // quiet for many windows so the debounce run restarts
      repeat (40) @(posedge clk);
      steps(3, n);
      check("irqs after window", 32'(n), 32'd1);
      check("step count", {16'h0, cnt}, 32'd6);
      rd(mfc_pkg::IDX_STEP_COUNT_HI, 8'h00);
      // threshold zero counts every step, so no window can swallow one
      bus(1'b1, mfc_pkg::IDX_STEP_DEBOUNCE, 8'h00);
      bus(1'b1, mfc_pkg::IDX_STEP_OPTION, 8'h08);
      step <= 1'b1;
      repeat (65529) @(posedge clk);
      steps(1, n);
      check("wrap irqs", 32'(n), 32'd1);
      check("count after wrap", {16'h0, cnt}, 32'd0);
      check("overflow pulses", 32'(n_ovf), 32'd1);
      @(posedge clk);
      check("pending reads", 32'(expq.size()), 32'd0);
      wrap_up();
   end
endmodule : test_mfc_config_page
`default_nettype wire
